// File: logic/timer_counter_unit.sv
`timescale 1ns/10ps
module timer_counter_unit
  import tc_pkg::*;
#(
  parameter int unsigned BASE_CYC = BASE_TICK_CYC,
  parameter int unsigned NUM      = NUM_LOC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              op_valid_i,
  input  wire op_t               op_i,
  input  wire logic              is_counter_i,
  input  wire logic [IDX_W-1:0]  index_i,
  input  wire logic              logic_result_i,
  input  wire logic [WORD_W-1:0] accu_i,
  output logic                   timer_status_scan_o,
  output logic [VAL_W-1:0]       binary_value_out_o,
  output logic [WORD_W-1:0]      bcd_value_out_o
);

  function automatic logic [VAL_W-1:0] bcd_to_bin(input logic [BCD_W-1:0] b);
    logic [13:0] acc;
    acc = 14'(b[11:8]) * 14'h064 + 14'(b[7:4]) * 14'h00A + 14'(b[3:0]);
    return acc[VAL_W-1:0];
  endfunction

  function automatic logic [BCD_W-1:0] bin_to_bcd(input logic [VAL_W-1:0] v);
    logic [BCD_W+VAL_W-1:0] sh;
    sh = {{BCD_W{1'b0}}, v};
    for (int n = 0; n < VAL_W; n++) begin
      for (int d = 0; d < 3; d++) begin
        if (sh[VAL_W+4*d +: 4] > 4'h4) begin
          sh[VAL_W+4*d +: 4] = sh[VAL_W+4*d +: 4] + 4'h3;
        end
      end
      sh = sh << 1;
    end
    return sh[BCD_W+VAL_W-1:VAL_W];
  endfunction

  tick_if tick_bus ();

  timebase_gen #(
    .BASE_CYC (BASE_CYC)
  ) u_timebase (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_bus  (tick_bus)
  );

  // Preset decode: three BCD digits and a time-base digit above them.
  wire logic [VAL_W-1:0] pre_val  = bcd_to_bin(accu_i[BCD_W-1:0]);
  wire logic [TB_W-1:0]  pre_base = accu_i[TB_LSB +: TB_W];
  wire logic             lr       = logic_result_i;
  wire logic             tmr_hit  = op_valid_i && !is_counter_i;
  wire logic             cnt_hit  = op_valid_i && is_counter_i;
  wire logic             clr_low  = (op_i == OP_PULSE) || (op_i == OP_ONDLY);

  tmode_t start_mode;
  always_comb begin
    unique case (op_i)
      OP_PULSE: start_mode = MODE_PULSE;
      OP_ONDLY: start_mode = MODE_ONDLY;
      OP_LATCH: start_mode = MODE_LATCH;
      OP_OFFDLY: start_mode = MODE_OFFDLY;
      default: start_mode = MODE_EXT;
    endcase
  end

  tmr_entry_t tmr_ff [NUM];
  cnt_word_t  cnt_ff [NUM];

  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_loc
      wire logic t_sel = tmr_hit && (index_i == IDX_W'(i));
      wire logic c_sel = cnt_hit && (index_i == IDX_W'(i));
      wire logic t_tick = tick_bus.tick[tmr_ff[i].base];
      wire logic t_rise = lr && !tmr_ff[i].start_f;
      wire logic t_fall = !lr && tmr_ff[i].start_f;
      wire logic t_en   = lr && !tmr_ff[i].en_f;
      wire logic t_last = (tmr_ff[i].val == 10'h001);
      wire logic c_set  = lr && !cnt_ff[i].set_f;
      wire logic c_up   = lr && !cnt_ff[i].up_f
                          && (cnt_ff[i].cnt != MAX_COUNT);
      wire logic c_dn   = lr && !cnt_ff[i].dn_f
                          && (cnt_ff[i].cnt != ZERO_COUNT);
      wire logic c_en   = lr && !cnt_ff[i].en_f;
      tmr_entry_t nxt_tmr;
      cnt_word_t  nxt_cnt;

      // The tick is applied first so that an operation which only scans
      // or repeats its result never stretches a running timer.
      always_comb begin
        nxt_tmr = tmr_ff[i];
        if (t_tick && tmr_ff[i].run) begin
          nxt_tmr.val = tmr_ff[i].val - 1'b1;
          if (t_last) begin
            nxt_tmr.run  = 1'b0;
            nxt_tmr.done = 1'b1;
          end
        end
        if (t_sel) begin
          unique case (op_i)
            OP_PULSE, OP_EXT, OP_ONDLY, OP_LATCH: begin
              nxt_tmr.start_f = lr;
              nxt_tmr.hold    = lr;
              if (t_rise) begin
                nxt_tmr.mode = start_mode;
                nxt_tmr.val  = pre_val;
                nxt_tmr.base = pre_base;
                nxt_tmr.run  = (pre_val != ZERO_COUNT);
                nxt_tmr.done = (pre_val == ZERO_COUNT);
              end else if (!lr && clr_low) begin
                nxt_tmr.val  = ZERO_COUNT;
                nxt_tmr.run  = 1'b0;
                nxt_tmr.done = 1'b0;
              end
            end
            OP_OFFDLY: begin
              nxt_tmr.start_f = lr;
              nxt_tmr.hold    = lr;
              nxt_tmr.mode    = MODE_OFFDLY;
              if (lr) begin
                nxt_tmr.val  = ZERO_COUNT;
                nxt_tmr.run  = 1'b0;
                nxt_tmr.done = 1'b0;
              end else if (t_fall) begin
                nxt_tmr.val  = pre_val;
                nxt_tmr.base = pre_base;
                nxt_tmr.run  = (pre_val != ZERO_COUNT);
                nxt_tmr.done = (pre_val == ZERO_COUNT);
              end
            end
            OP_RESET: begin
              if (lr) begin
                nxt_tmr.val  = ZERO_COUNT;
                nxt_tmr.run  = 1'b0;
                nxt_tmr.done = 1'b0;
                nxt_tmr.hold = 1'b0;
              end
            end
            OP_ENABLE: begin
              nxt_tmr.en_f = lr;
              if (t_en) begin
                nxt_tmr.start_f = 1'b0;
              end
            end
            OP_SCAN: begin
            end
          endcase
        end
      end

      always_comb begin
        nxt_cnt = cnt_ff[i];
        if (c_sel) begin
          unique case (op_i)
            OP_EXT: begin
              nxt_cnt.set_f = lr;
              if (c_set) begin
                nxt_cnt.cnt = pre_val;
              end
            end
            OP_LATCH: begin
              nxt_cnt.up_f = lr;
              if (c_up) begin
                nxt_cnt.cnt = cnt_ff[i].cnt + 1'b1;
              end
            end
            OP_OFFDLY: begin
              nxt_cnt.dn_f = lr;
              if (c_dn) begin
                nxt_cnt.cnt = cnt_ff[i].cnt - 1'b1;
              end
            end
            OP_RESET: begin
              if (lr) begin
                nxt_cnt.cnt = ZERO_COUNT;
              end
            end
            OP_ENABLE: begin
              nxt_cnt.en_f = lr;
              if (c_en) begin
                nxt_cnt.set_f = 1'b0;
                nxt_cnt.up_f  = 1'b0;
                nxt_cnt.dn_f  = 1'b0;
              end
            end
            OP_PULSE, OP_ONDLY, OP_SCAN: begin
              nxt_cnt = cnt_ff[i];
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          tmr_ff[i] <= '0;
          cnt_ff[i] <= '0;
        end else if (ce_i) begin
          tmr_ff[i] <= nxt_tmr;
          cnt_ff[i] <= nxt_cnt;
        end
      end
    end
  endgenerate

  // The readouts follow the location named by the most recent operation.
  logic [IDX_W-1:0] idx_ff;
  logic             cls_ff;

  wire tmr_entry_t  rd_tmr = tmr_ff[idx_ff];
  wire cnt_word_t   rd_cnt = cnt_ff[idx_ff];

  logic tmr_status;
  always_comb begin
    unique case (rd_tmr.mode)
      MODE_PULSE, MODE_EXT: tmr_status = rd_tmr.run;
      MODE_ONDLY: tmr_status = rd_tmr.done && rd_tmr.hold;
      MODE_LATCH: tmr_status = rd_tmr.done;
      MODE_OFFDLY: tmr_status = rd_tmr.run || rd_tmr.hold;
      default: tmr_status = 1'b0;
    endcase
  end

  wire logic             nxt_status = cls_ff ? (rd_cnt.cnt != ZERO_COUNT)
                                             : tmr_status;
  wire logic [VAL_W-1:0] nxt_bin    = cls_ff ? rd_cnt.cnt : rd_tmr.val;
  wire logic [BCD_W-1:0] nxt_digits = bin_to_bcd(nxt_bin);
  wire logic [TB_W-1:0]  nxt_tb     = cls_ff ? '0 : rd_tmr.base;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_ff              <= '0;
      cls_ff              <= 1'b0;
      timer_status_scan_o <= 1'b0;
      binary_value_out_o  <= '0;
      bcd_value_out_o     <= '0;
    end else if (ce_i) begin
      if (op_valid_i) begin
        idx_ff <= index_i;
        cls_ff <= is_counter_i;
      end
      timer_status_scan_o <= nxt_status;
      binary_value_out_o  <= nxt_bin;
      bcd_value_out_o     <= {2'b00, nxt_tb, nxt_digits};
    end
  end

endmodule

// File: inc/tc_pkg.sv
package tc_pkg;

  localparam int unsigned NUM_LOC       = 128;
  localparam int unsigned IDX_W         = 7;
  localparam int unsigned VAL_W         = 10;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned BCD_W         = 12;
  localparam int unsigned TB_LSB        = 12;
  localparam int unsigned TB_W          = 2;
  localparam int unsigned NUM_BASES     = 4;
  localparam logic [9:0]  MAX_COUNT     = 10'h3E7;
  localparam logic [9:0]  ZERO_COUNT    = 10'h000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BASE_TICK_NS  = 10000000;
  localparam int unsigned BASE_TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DECADE        = 10;

  typedef enum logic [2:0] {
    OP_SCAN,
    OP_PULSE,
    OP_EXT,
    OP_ONDLY,
    OP_LATCH,
    OP_OFFDLY,
    OP_RESET,
    OP_ENABLE
  } op_t;

  typedef enum logic [2:0] {
    MODE_PULSE,
    MODE_EXT,
    MODE_ONDLY,
    MODE_LATCH,
    MODE_OFFDLY
  } tmode_t;

  typedef struct packed {
    tmode_t            mode;
    logic              run;
    logic              done;
    logic              hold;
    logic              start_f;
    logic              en_f;
    logic [TB_W-1:0]   base;
    logic [VAL_W-1:0]  val;
  } tmr_entry_t;

  typedef struct packed {
    logic              en_f;
    logic              dn_f;
    logic              up_f;
    logic              set_f;
    logic [VAL_W-1:0]  cnt;
  } cnt_word_t;

endpackage

// File: inc/tick_if.sv
`timescale 1ns/10ps
interface tick_if;
  import tc_pkg::*;
  logic [NUM_BASES-1:0] tick;
  modport gen (output tick);
  modport use_tick (input tick);
endinterface

// File: logic/timebase_gen.sv
`timescale 1ns/10ps
module timebase_gen
  import tc_pkg::*;
#(
  parameter int unsigned BASE_CYC = BASE_TICK_CYC
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  tick_if.gen       tick_bus
);

  localparam int unsigned   CW        = (BASE_CYC > 1) ? $clog2(BASE_CYC) : 1;
  localparam logic [CW-1:0] BASE_LAST = CW'(BASE_CYC - 1);
  localparam logic [3:0]    DEC_LAST  = 4'(DECADE - 1);

  logic [CW-1:0]             base_cnt_ff;
  logic [NUM_BASES-1:0]      tick_ff;
  wire logic [NUM_BASES-1:0] carry;

  assign carry[0]      = (base_cnt_ff == BASE_LAST);
  assign tick_bus.tick = tick_ff;

  // The finest tick marks every hundredth of a second.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_cnt_ff <= '0;
      tick_ff     <= '0;
    end else if (ce_i) begin
      base_cnt_ff <= carry[0] ? '0 : base_cnt_ff + 1'b1;
      tick_ff     <= carry;
    end
  end

  // Each coarser base divides the one below it by ten.
  genvar k;
  generate
    for (k = 1; k < NUM_BASES; k++) begin : g_dec
      logic [3:0] dec_ff;
      assign carry[k] = carry[k-1] && (dec_ff == DEC_LAST);
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          dec_ff <= 4'h0;
        end else if (ce_i && carry[k-1]) begin
          dec_ff <= (dec_ff == DEC_LAST) ? 4'h0 : dec_ff + 4'h1;
        end
      end
    end
  endgenerate

endmodule

// File: bench/tc_checker.sv
`timescale 1ns/10ps
module tc_checker
  import tc_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              op_valid_i,
  input wire op_t               op_i,
  input wire logic              is_counter_i,
  input wire logic [IDX_W-1:0]  index_i,
  input wire logic              logic_result_i,
  input wire logic [WORD_W-1:0] accu_i,
  input wire logic              timer_status_scan_o,
  input wire logic [VAL_W-1:0]  binary_value_out_o,
  input wire logic [WORD_W-1:0] bcd_value_out_o
);
  logic [1:0]       idle_ff;
  logic [IDX_W-1:0] idx_ff;
  logic             cnt_ff;
  logic             arm_ff;
  logic             take;
  logic             same;
  logic             tmr_off;
  logic [9:0]       pre;
  logic [9:0]       bin;
  logic [11:0]      bcd_of_bin;

  assign take = op_valid_i && ce_i;
  assign same = idle_ff >= 2'h2 && idx_ff == index_i && cnt_ff
                && is_counter_i;
  assign tmr_off = take && !is_counter_i && op_i == OP_OFFDLY;
  assign pre = 10'(accu_i[11:8] * 100 + accu_i[7:4] * 10 + accu_i[3:0]);
  assign bin = binary_value_out_o;
  assign bcd_of_bin = {4'(bin / 100), 4'((bin / 10) % 10), 4'(bin % 10)};

  // Tracks the last addressed location and how long it has been idle.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_ff <= 2'h0;
      idx_ff  <= '0;
      cnt_ff  <= 1'b0;
      arm_ff  <= 1'b0;
    end else if (take) begin
      idle_ff <= 2'h0;
      idx_ff  <= index_i;
      cnt_ff  <= is_counter_i;
      arm_ff  <= tmr_off && logic_result_i;
    end else if (idle_ff != 2'h3) begin
      idle_ff <= idle_ff + 2'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cnt(op_t o);
    take && same && op_i == o;
  endsequence

  property p_bcd;
    bcd_value_out_o[11:0] == bcd_of_bin && bcd_value_out_o[15:14] == 2'h0;
  endproperty
  property p_max;
    bin <= MAX_COUNT;
  endproperty
  property p_rst;
    take && is_counter_i && op_i == OP_RESET && logic_result_i
      |-> ##2 bin == ZERO_COUNT && bcd_value_out_o == 16'h0000;
  endproperty
  property p_off_hold;
    tmr_off && logic_result_i |-> ##2 timer_status_scan_o && bin == 10'h000;
  endproperty
  property p_off_run;
    tmr_off && !logic_result_i && arm_ff && idx_ff == index_i && pre > 10'h1
      |-> ##2 timer_status_scan_o && bin != 10'h000;
  endproperty
  property p_up;
    s_cnt(OP_LATCH) |-> ##2 bin == $past(bin, 2)
      || bin == $past(bin, 2) + 10'h1;
  endproperty
  property p_dn;
    s_cnt(OP_OFFDLY) |-> ##2 bin == $past(bin, 2)
      || bin == $past(bin, 2) - 10'h1;
  endproperty
  property p_no_edge;
    (s_cnt(OP_EXT) or s_cnt(OP_LATCH) or s_cnt(OP_OFFDLY)) ##0
      !logic_result_i |-> ##2 bin == $past(bin, 2);
  endproperty
  property p_set;
    s_cnt(OP_EXT) ##0 logic_result_i
      |-> ##2 bin == $past(bin, 2) || bin == $past(pre, 2);
  endproperty

  a_bcd: assert property (p_bcd) else $error("bcd readout mismatch");
  a_max: assert property (p_max) else $error("count above limit");
  a_rst: assert property (p_rst) else $error("reset left count");
  a_off_hold: assert property (p_off_hold) else $error("hold wrong");
  a_off_run: assert property (p_off_run) else $error("not running");
  a_up: assert property (p_up) else $error("bad up step");
  a_dn: assert property (p_dn) else $error("bad down step");
  a_no_edge: assert property (p_no_edge) else $error("acted on low");
  a_set: assert property (p_set) else $error("bad set value");
endmodule

// File: bench/program_model.sv
`timescale 1ns/10ps
module program_model
  import tc_pkg::*;
(
  input  wire logic          ref_clk_i,
  output logic               op_valid_o,
  output op_t                op_o,
  output logic               is_counter_o,
  output logic [IDX_W-1:0]   index_o,
  output logic               logic_result_o,
  output logic [WORD_W-1:0]  accu_o
);
  initial begin
    op_valid_o = 1'b0;
    op_o = OP_SCAN;
    is_counter_o = 1'b0;
    index_o = '0;
    logic_result_o = 1'b0;
    accu_o = '0;
  end

  // Issues one operation, valid for exactly one taking edge, except a counter pulse or on-delay, which it drops.
  task automatic apply(input op_t o, input logic c, input logic [6:0] i,
                       input logic lr, input logic [15:0] a);
    if (c && (o == OP_PULSE || o == OP_ONDLY)) return;
    @(posedge ref_clk_i);
    op_valid_o <= 1'b1;
    op_o <= o;
    is_counter_o <= c;
    index_o <= i;
    logic_result_o <= lr;
    accu_o <= a;
    @(posedge ref_clk_i);
    op_valid_o <= 1'b0;
  endtask
endmodule

// File: bench/plc_timer_counter_ops_test.sv
`timescale 1ns/10ps
module plc_timer_counter_ops_test;
  import tc_pkg::*;
  logic                ref_clk_i;
  logic                rst_i;
  logic                ce_i;
  logic                op_valid_i;
  op_t                 op_i;
  logic                is_counter_i;
  logic [IDX_W-1:0]    index_i;
  logic                logic_result_i;
  logic [WORD_W-1:0]   accu_i;
  logic                timer_status_scan_o;
  logic [VAL_W-1:0]    binary_value_out_o;
  logic [WORD_W-1:0]   bcd_value_out_o;
  int                  errors;
  int                  checks_done;
  op_t                 mode_tab [5] = '{OP_PULSE, OP_EXT, OP_ONDLY, OP_LATCH,
                                        OP_OFFDLY};
  logic [4:0]          early = 5'h13;
  logic [4:0]          late = 5'h1C;

  program_model program_model_i (.ref_clk_i(ref_clk_i),
    .op_valid_o(op_valid_i), .op_o(op_i), .is_counter_o(is_counter_i),
    .index_o(index_i), .logic_result_o(logic_result_i), .accu_o(accu_i));

  timer_counter_unit #(.BASE_CYC(4)) timer_counter_unit_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .is_counter_i(is_counter_i),
    .index_i(index_i), .logic_result_i(logic_result_i), .accu_i(accu_i),
    .timer_status_scan_o(timer_status_scan_o),
    .binary_value_out_o(binary_value_out_o),
    .bcd_value_out_o(bcd_value_out_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] bcd2bin(input logic [15:0] b);
    return 16'(b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
  endfunction

  task automatic stop_test;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic op(input op_t o, input logic c, input logic [6:0] i,
                    input logic lr, input logic [15:0] a);
    program_model_i.apply(o, c, i, lr, a);
    wait_clk(1);
  endtask

  task automatic exp_cnt(input logic [15:0] b);
    cmp("binary", bcd2bin(b), {6'h00, binary_value_out_o});
    cmp("bcd", b, bcd_value_out_o);
  endtask

  task automatic exp_st(input logic s);
    cmp("status", {15'h0000, s}, {15'h0000, timer_status_scan_o});
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk_i);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_clk(1);
    exp_cnt(16'h0000);
    op(OP_EXT, 1'b1, 7'h05, 1'b1, 16'h0123);
    exp_cnt(16'h0123);
    op(OP_EXT, 1'b1, 7'h05, 1'b1, 16'h0456);
    exp_cnt(16'h0123);
    op(OP_EXT, 1'b1, 7'h05, 1'b0, 16'h0456);
    op(OP_EXT, 1'b1, 7'h05, 1'b1, 16'h0456);
    exp_cnt(16'h0456);
    op(OP_LATCH, 1'b1, 7'h05, 1'b1, 16'h0000);
    exp_cnt(16'h0457);
    op(OP_LATCH, 1'b1, 7'h05, 1'b1, 16'h0000);
    exp_cnt(16'h0457);
    op(OP_OFFDLY, 1'b1, 7'h05, 1'b1, 16'h0000);
    exp_cnt(16'h0456);
    op(OP_OFFDLY, 1'b1, 7'h05, 1'b1, 16'h0000);
    exp_cnt(16'h0456);
    op(OP_EXT, 1'b1, 7'h05, 1'b0, 16'h0998);
    op(OP_EXT, 1'b1, 7'h05, 1'b1, 16'h0998);
    for (int k = 0; k < 2; k++) begin
      op(OP_LATCH, 1'b1, 7'h05, 1'b0, 16'h0000);
      op(OP_LATCH, 1'b1, 7'h05, 1'b1, 16'h0000);
      exp_cnt(16'h0999);
    end
    op(OP_RESET, 1'b1, 7'h05, 1'b1, 16'h0000);
    exp_cnt(16'h0000);
    op(OP_RESET, 1'b1, 7'h05, 1'b0, 16'h0000);
    op(OP_OFFDLY, 1'b1, 7'h05, 1'b0, 16'h0000);
    op(OP_OFFDLY, 1'b1, 7'h05, 1'b1, 16'h0000);
    exp_cnt(16'h0000);
    op(OP_EXT, 1'b1, 7'h07, 1'b1, 16'h0010);
    op(OP_ENABLE, 1'b1, 7'h07, 1'b1, 16'h0000);
    op(OP_EXT, 1'b1, 7'h07, 1'b1, 16'h0020);
    exp_cnt(16'h0020);
    op(OP_ENABLE, 1'b1, 7'h07, 1'b1, 16'h0000);
    op(OP_EXT, 1'b1, 7'h07, 1'b1, 16'h0030);
    exp_cnt(16'h0020);
    for (int k = 0; k < 5; k++) begin
      op(mode_tab[k], 1'b0, 7'(20 + k), 1'b1, 16'h0003);
      exp_st(early[k]);
      wait_clk(20);
      op(OP_SCAN, 1'b0, 7'(20 + k), 1'b0, 16'h0000);
      exp_st(late[k]);
    end
    op(OP_PULSE, 1'b0, 7'h14, 1'b1, 16'h0003);
    exp_st(1'b0);
    op(OP_ENABLE, 1'b0, 7'h14, 1'b1, 16'h0000);
    op(OP_PULSE, 1'b0, 7'h14, 1'b1, 16'h0003);
    exp_st(1'b1);
    op(OP_RESET, 1'b0, 7'h17, 1'b1, 16'h0000);
    exp_st(1'b0);
    op(OP_OFFDLY, 1'b0, 7'h1E, 1'b1, 16'h1002);
    exp_st(1'b1);
    cmp("held value", 16'h0000, {6'h00, binary_value_out_o});
    op(OP_OFFDLY, 1'b0, 7'h1E, 1'b0, 16'h1002);
    exp_st(1'b1);
    cmp("time base", 16'h1000, bcd_value_out_o & 16'h3000);
    wait_clk(30);
    exp_st(1'b1);
    @(posedge ref_clk_i) ce_i <= 1'b0;
    wait_clk(100);
    exp_st(1'b1);
    @(posedge ref_clk_i) ce_i <= 1'b1;
    wait_clk(55);
    exp_st(1'b0);
    exp_cnt(16'h1000);
    stop_test();
  end
endmodule

bind timer_counter_unit tc_checker tc_checker_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .op_valid_i(op_valid_i), .op_i(op_i), .is_counter_i(is_counter_i),
  .index_i(index_i), .logic_result_i(logic_result_i), .accu_i(accu_i),
  .timer_status_scan_o(timer_status_scan_o),
  .binary_value_out_o(binary_value_out_o),
  .bcd_value_out_o(bcd_value_out_o));
